// File: hw/slot_cap_pkg.sv
// Purpose: constants and types shared by the slot capability register bank
// Assumes: 32-bit classic Wishbone register port, byte addressed
// Notes: all stored fields reset to zero
//
// Overview of operation
// [RULE1] set bw change flag on autonomous phy speed/width change, not reliability
// [RULE2] set bw change flag when partner-initiated change is marked autonomous
// [RULE3] hold bw change flag at zero while bw notify capability is off
// [RULE4] bw change flag is always zero when the port is upstream
// [RULE5] writing one clears the bw change flag; writing zero leaves it
// [RULE6] all slot capability fields read zero while slot is not implemented
// [RULE7] presence flags in bits 0..4 for button, power, latch, indicators
// [RULE8] bit 5 says slot device may be removed without notice
// [RULE9] bit 6 says the slot supports hot-plug
// [RULE10] read-write power limit value in bits 14:7, reset zero
// [RULE11] read-write power limit scale in bits 16:15, four decimal multipliers
// [RULE12] every software write of slot capability sends a power limit message; writes made during a send share one follow-up message
// [RULE13] entering data link up also sends a power limit message
// [RULE14] bit 17 says an electromechanical interlock exists
// [RULE15] bit 18 is hardwired zero; command completion is always notified
// [RULE16] physical slot number in bits 31:19, reset zero
// [RULE17] software should set slot number zero for board-level links
package slot_cap_pkg;

   // -----------------------------------------------------------
   // register byte addresses
   // -----------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] ADDR_LINK = 8'h50;
   localparam logic [7:0] ADDR_SLOT_CAP = 8'h54;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h60;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h64;
   localparam logic [7:0] ADDR_PORT_CFG = 8'h68;

   // -----------------------------------------------------------
   // slot capability layout
   // -----------------------------------------------------------
   localparam int ATTN_BTN_BIT = 0;
   localparam int PWR_CTRL_BIT = 1;
   localparam int LATCH_BIT = 2;
   localparam int ATTN_IND_BIT = 3;
   localparam int PWR_IND_BIT = 4;
   localparam int SURPRISE_BIT = 5;
   localparam int HOTPLUG_BIT = 6;
   localparam int PLV_LSB = 7;
   localparam int PLV_MSB = 14;
   localparam int PLS_LSB = 15;
   localparam int PLS_MSB = 16;
   localparam int INTERLOCK_BIT = 17;
   localparam int NO_CMD_DONE_BIT = 18;
   localparam int SLOT_NUM_LSB = 19;
   localparam int SLOT_NUM_MSB = 31;
   localparam logic [31:0] SLOT_RWL_MASK = 32'hFFFA007F;
   localparam logic [31:0] SLOT_RW_MASK = 32'h0001FF80;
   localparam logic [31:0] SLOT_CAP_RST = 32'h00000000;

   // power limit scale codes
   localparam logic [1:0] SCALE_X1 = 2'h0;
   localparam logic [1:0] SCALE_XP1 = 2'h1;
   localparam logic [1:0] SCALE_XP01 = 2'h2;
   localparam logic [1:0] SCALE_XP001 = 2'h3;

   // -----------------------------------------------------------
   // link status word: status half sits in bits 31:16
   // -----------------------------------------------------------
   localparam int LINK_STS_LSB = 16;
   localparam int AUTO_BW_BIT = 15;
   localparam int AUTO_BW_WORD_BIT = 31;
   localparam logic AUTO_BW_RST = 1'b0;

   // -----------------------------------------------------------
   // port configuration, interrupt status and mask
   // -----------------------------------------------------------
   localparam int CFG_W = 4;
   localparam int CFG_SLOT_BIT = 0;
   localparam int CFG_BWN_BIT = 1;
   localparam int CFG_UPSTREAM_BIT = 2;
   localparam int CFG_LOCK_BIT = 3;
   localparam logic [3:0] PORT_CFG_RST = 4'h0;
   localparam int IRQ_W = 2;
   localparam int IRQ_BW_BIT = 0;
   localparam int IRQ_SPL_BIT = 1;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // power limit message sender states
   typedef enum logic [0:0] {
      SPL_IDLE = 1'b0,
      SPL_BUSY = 1'b1
   } spl_state_t;

endpackage

// File: hw/spl_msg_tx.sv
// Purpose: launches one power limit message per request taken while idle, with handshake
// Assumes: value and scale inputs are registered in the same clock domain
// Notes: requests during a send are merged into one follow-up message
`timescale 1ns/100ps
`default_nettype none
module spl_msg_tx (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // request side
   input wire logic trigger,
   input wire logic [7:0] value,
   input wire logic [1:0] scale,
   output logic sent,
   // message side
   output logic msg_valid,
   input wire logic msg_ready,
   output logic [7:0] msg_value,
   output logic [1:0] msg_scale
);

   typedef struct packed {
      slot_cap_pkg::spl_state_t state;
      logic pending;
      logic valid;
      logic [7:0] value;
      logic [1:0] scale;
      logic sent;
   } tx_state_t;

   tx_state_t st_ff;
   tx_state_t nxt_st;

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sent = 1'b0;
      nxt_st.pending = st_ff.pending | trigger;
      case (st_ff.state)
         slot_cap_pkg::SPL_IDLE: begin
            // launch a cycle after the request so a write is already stored
            if (st_ff.pending) begin
               nxt_st.state = slot_cap_pkg::SPL_BUSY;
               nxt_st.valid = 1'b1;
               nxt_st.value = value;
               nxt_st.scale = scale;
               nxt_st.pending = trigger;
            end
         end
         slot_cap_pkg::SPL_BUSY: begin
            if (msg_ready) begin
               nxt_st.state = slot_cap_pkg::SPL_IDLE;
               nxt_st.valid = 1'b0;
               nxt_st.sent = 1'b1;
            end
         end
         default: begin
            nxt_st.state = slot_cap_pkg::SPL_IDLE;
            nxt_st.valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign msg_valid = st_ff.valid;
   assign msg_value = st_ff.value;
   assign msg_scale = st_ff.scale;
   assign sent = st_ff.sent;

endmodule // spl_msg_tx
`default_nettype wire

// File: hw/slot_cap_regs.sv
// Purpose: slot capability register and autonomous bandwidth status flag
// Assumes: phy events and link state come from logic on sys_clk
// Notes: classic Wishbone slave, one wait state, unmapped reads give zero
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module slot_cap_regs (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [slot_cap_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // physical and data link layer status
   input wire logic phy_auto_bw_chg,
   input wire logic partner_auto_bw_chg,
   input wire logic dl_up,
   // power limit message to the downstream device
   output logic spl_msg_valid,
   input wire logic spl_msg_ready,
   output logic [7:0] spl_msg_value,
   output logic [1:0] spl_msg_scale,
   // interrupt
   output logic irq
);

   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   typedef struct packed {
      logic [31:0] slot_cap;
      logic autonomous_bw_change_flag;
      logic [slot_cap_pkg::CFG_W-1:0] port_cfg;
      logic [slot_cap_pkg::IRQ_W-1:0] irq_stat;
      logic [slot_cap_pkg::IRQ_W-1:0] irq_mask;
      logic [31:0] dat;
      logic ack;
      logic irq;
      logic dl_up_prev;
   } regs_state_t;

   regs_state_t st_ff;
   regs_state_t nxt_st;

   logic spl_trigger;
   logic spl_sent;
   logic [31:0] slot_view;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [31:0] wmask
   );
      return (old_v & ~wmask) | (new_v & wmask);
   endfunction

   function automatic logic hit(
      input logic [slot_cap_pkg::ADR_W-1:0] adr,
      input logic [7:0] reg_adr
   );
      return adr[slot_cap_pkg::ADR_W-1:2] == reg_adr[7:2];
   endfunction

   // -----------------------------------------------------------
   // slot capability as software sees it
   // -----------------------------------------------------------
   always_comb begin
      slot_view = st_ff.slot_cap;
      slot_view[slot_cap_pkg::NO_CMD_DONE_BIT] = 1'b0; // [RULE15]
      if (!st_ff.port_cfg[slot_cap_pkg::CFG_SLOT_BIT]) begin
         slot_view = slot_cap_pkg::SLOT_CAP_RST; // [RULE6]
      end
   end

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   always_comb begin
      logic access;
      logic wr;
      logic rd;
      logic [31:0] wm;
      logic [31:0] slot_wr_mask;
      logic [31:0] cfg_word;
      logic [31:0] mask_word;
      logic [31:0] link_word;
      logic [31:0] rd_word;
      logic bw_eligible;
      logic bw_set;
      logic bw_clr;
      logic [slot_cap_pkg::IRQ_W-1:0] irq_set;
      logic [slot_cap_pkg::IRQ_W-1:0] irq_clr;

      access = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      wm = 32'h00000000;
      slot_wr_mask = 32'h00000000;
      cfg_word = 32'h00000000;
      mask_word = 32'h00000000;
      link_word = 32'h00000000;
      rd_word = 32'h00000000;
      bw_eligible = 1'b0;
      bw_set = 1'b0;
      bw_clr = 1'b0;
      irq_set = '0;
      irq_clr = '0;
      spl_trigger = 1'b0;

      nxt_st = st_ff;

      // bus handshake: one request taken per ack
      access = wb_cyc_i & wb_stb_i & ~st_ff.ack;
      wr = access & wb_we_i;
      rd = access & ~wb_we_i;
      wm = byte_mask(wb_sel_i);
      nxt_st.ack = access;

      // ---------------------------------------------------------
      // slot capability writes
      // ---------------------------------------------------------
      slot_wr_mask = slot_cap_pkg::SLOT_RW_MASK; // [RULE10] [RULE11]
      if (!st_ff.port_cfg[slot_cap_pkg::CFG_LOCK_BIT]) begin
         // locked fields: presence, surprise, hot-plug, interlock, slot number
         slot_wr_mask = slot_wr_mask | slot_cap_pkg::SLOT_RWL_MASK;
      end
      if (wr && hit(wb_adr_i, slot_cap_pkg::ADDR_SLOT_CAP)) begin
         if (st_ff.port_cfg[slot_cap_pkg::CFG_SLOT_BIT]) begin
            // [RULE7] [RULE8] [RULE9] [RULE14] [RULE16]
            nxt_st.slot_cap = merge(st_ff.slot_cap, wb_dat_i,
                                    wm & slot_wr_mask);
         end
         spl_trigger = 1'b1; // [RULE12]
      end

      // ---------------------------------------------------------
      // data link up entry
      // ---------------------------------------------------------
      nxt_st.dl_up_prev = dl_up;
      if (dl_up && !st_ff.dl_up_prev) begin
         spl_trigger = 1'b1; // [RULE13]
      end

      // ---------------------------------------------------------
      // autonomous bandwidth change flag
      // ---------------------------------------------------------
      bw_eligible = st_ff.port_cfg[slot_cap_pkg::CFG_BWN_BIT] &
                    ~st_ff.port_cfg[slot_cap_pkg::CFG_UPSTREAM_BIT];
      bw_set = phy_auto_bw_chg | partner_auto_bw_chg; // [RULE1] [RULE2]
      bw_clr = wr & hit(wb_adr_i, slot_cap_pkg::ADDR_LINK) &
               wm[slot_cap_pkg::AUTO_BW_WORD_BIT] &
               wb_dat_i[slot_cap_pkg::AUTO_BW_WORD_BIT];
      if (!bw_eligible) begin
         nxt_st.autonomous_bw_change_flag = 1'b0; // [RULE3] [RULE4]
      end else if (bw_set) begin
         // a change in the clearing cycle is kept
         nxt_st.autonomous_bw_change_flag = 1'b1; // [RULE1] [RULE2]
      end else if (bw_clr) begin
         nxt_st.autonomous_bw_change_flag = 1'b0; // [RULE5]
      end

      // ---------------------------------------------------------
      // port configuration and interrupt mask
      // ---------------------------------------------------------
      cfg_word = merge({{(32-slot_cap_pkg::CFG_W){1'b0}}, st_ff.port_cfg},
                       wb_dat_i, wm);
      if (wr && hit(wb_adr_i, slot_cap_pkg::ADDR_PORT_CFG)) begin
         nxt_st.port_cfg = cfg_word[slot_cap_pkg::CFG_W-1:0];
      end
      mask_word = merge({{(32-slot_cap_pkg::IRQ_W){1'b0}}, st_ff.irq_mask},
                        wb_dat_i, wm);
      if (wr && hit(wb_adr_i, slot_cap_pkg::ADDR_IRQ_MASK)) begin
         nxt_st.irq_mask = mask_word[slot_cap_pkg::IRQ_W-1:0];
      end

      // ---------------------------------------------------------
      // interrupt status: write one to clear, set wins
      // ---------------------------------------------------------
      irq_set[slot_cap_pkg::IRQ_BW_BIT] = bw_eligible & bw_set;
      irq_set[slot_cap_pkg::IRQ_SPL_BIT] = spl_sent;
      if (wr && hit(wb_adr_i, slot_cap_pkg::ADDR_IRQ_STAT)) begin
         irq_clr = wb_dat_i[slot_cap_pkg::IRQ_W-1:0] &
                   wm[slot_cap_pkg::IRQ_W-1:0];
      end
      nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_set;
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

      // ---------------------------------------------------------
      // read data
      // ---------------------------------------------------------
      link_word[slot_cap_pkg::LINK_STS_LSB + slot_cap_pkg::AUTO_BW_BIT] =
         st_ff.autonomous_bw_change_flag;
      if (hit(wb_adr_i, slot_cap_pkg::ADDR_LINK)) begin
         rd_word = link_word;
      end else if (hit(wb_adr_i, slot_cap_pkg::ADDR_SLOT_CAP)) begin
         rd_word = slot_view;
      end else if (hit(wb_adr_i, slot_cap_pkg::ADDR_IRQ_STAT)) begin
         rd_word = {{(32-slot_cap_pkg::IRQ_W){1'b0}}, st_ff.irq_stat};
      end else if (hit(wb_adr_i, slot_cap_pkg::ADDR_IRQ_MASK)) begin
         rd_word = {{(32-slot_cap_pkg::IRQ_W){1'b0}}, st_ff.irq_mask};
      end else if (hit(wb_adr_i, slot_cap_pkg::ADDR_PORT_CFG)) begin
         rd_word = {{(32-slot_cap_pkg::CFG_W){1'b0}}, st_ff.port_cfg};
      end
      if (rd) begin
         nxt_st.dat = rd_word;
      end
   end

   // -----------------------------------------------------------
   // state register
   // -----------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         st_ff <= '0;
         st_ff.slot_cap <= slot_cap_pkg::SLOT_CAP_RST;
         st_ff.autonomous_bw_change_flag <= slot_cap_pkg::AUTO_BW_RST;
         st_ff.port_cfg <= slot_cap_pkg::PORT_CFG_RST;
         st_ff.irq_stat <= slot_cap_pkg::IRQ_RST;
         st_ff.irq_mask <= slot_cap_pkg::IRQ_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -----------------------------------------------------------
   // power limit message sender
   // -----------------------------------------------------------
   spl_msg_tx u_spl_msg_tx (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .trigger(spl_trigger),
      .value(slot_view[slot_cap_pkg::PLV_MSB:slot_cap_pkg::PLV_LSB]),
      .scale(slot_view[slot_cap_pkg::PLS_MSB:slot_cap_pkg::PLS_LSB]),
      .sent(spl_sent),
      .msg_valid(spl_msg_valid),
      .msg_ready(spl_msg_ready),
      .msg_value(spl_msg_value),
      .msg_scale(spl_msg_scale)
   );

   assign wb_dat_o = st_ff.dat;
   assign wb_ack_o = st_ff.ack;
   assign irq = st_ff.irq;

endmodule // slot_cap_regs
`default_nettype wire

// File: dv/slot_cap_regs_chk.sv
// Purpose: port-level checks of the slot capability register bank
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of slot_cap_regs
`timescale 1ns/100ps
`default_nettype none
module slot_cap_regs_chk (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [slot_cap_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // link status
   input wire logic phy_auto_bw_chg,
   input wire logic partner_auto_bw_chg,
   input wire logic dl_up,
   // message and interrupt
   input wire logic spl_msg_valid,
   input wire logic spl_msg_ready,
   input wire logic [7:0] spl_msg_value,
   input wire logic [1:0] spl_msg_scale,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic take, rd_slot, rd_link, acc;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign acc = spl_msg_valid && spl_msg_ready;
   assign rd_slot = wb_ack_o && wb_cyc_i && !wb_we_i
      && wb_adr_i[7:2] == slot_cap_pkg::ADDR_SLOT_CAP[7:2];
   assign rd_link = wb_ack_o && wb_cyc_i && !wb_we_i
      && wb_adr_i[7:2] == slot_cap_pkg::ADDR_LINK[7:2];
   property p_ack_next; take |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_cause; wb_ack_o |-> $past(take); endproperty
   property p_msg_write;
      take && wb_we_i && !spl_msg_valid
      && wb_adr_i[7:2] == slot_cap_pkg::ADDR_SLOT_CAP[7:2]
      |-> ##2 spl_msg_valid;
   endproperty
   property p_msg_link; $rose(dl_up) && !spl_msg_valid |-> ##2 spl_msg_valid;
   endproperty
   property p_msg_hold;
      spl_msg_valid && !spl_msg_ready |=> spl_msg_valid
      && $stable(spl_msg_value) && $stable(spl_msg_scale);
   endproperty
   property p_msg_done; acc |=> !spl_msg_valid; endproperty
   property p_no_cmd_done;
      rd_slot |-> !wb_dat_o[slot_cap_pkg::NO_CMD_DONE_BIT];
   endproperty
   property p_link_word; rd_link |-> wb_dat_o[30:0] == 31'h0; endproperty
   property p_irq_cause;
      $rose(irq) |-> $past(phy_auto_bw_chg || partner_auto_bw_chg
      || (wb_cyc_i && wb_we_i)) || $past(acc) || $past(acc, 2);
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
   a_msg_write: assert property (p_msg_write)
      else $error("no message after write");
   a_msg_link: assert property (p_msg_link)
      else $error("no message on link up");
   a_msg_hold: assert property (p_msg_hold)
      else $error("message changed while waiting");
   a_msg_done: assert property (p_msg_done) else $error("valid after accept");
   a_no_cmd_done: assert property (p_no_cmd_done)
      else $error("bit 18 read as one");
   a_link_word: assert property (p_link_word)
      else $error("link word low bits not zero");
   a_irq_cause: assert property (p_irq_cause)
      else $error("irq rose without cause");
   c_write: cover property (p_msg_write);
   c_accept: cover property (acc);
   c_irq: cover property ($rose(irq));
endmodule // slot_cap_regs_chk
bind slot_cap_regs slot_cap_regs_chk u_slot_cap_regs_chk (.sys_clk, .nrst,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .phy_auto_bw_chg, .partner_auto_bw_chg, .dl_up,
   .spl_msg_valid, .spl_msg_ready, .spl_msg_value, .spl_msg_scale, .irq);
`default_nettype wire

// File: dv/spl_sink_model.sv
// Purpose: downstream device end of the power limit message handshake
// Assumes: same clock as the register bank
// Notes: accepts after a stall set by the bench; ready only while valid
`timescale 1ns/100ps
`default_nettype none
module spl_sink_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // message handshake
   input wire logic msg_valid,
   output logic msg_ready,
   input wire logic [7:0] msg_value,
   input wire logic [1:0] msg_scale,
   // bench side
   input wire logic [3:0] stall,
   output logic [7:0] got_value,
   output logic [1:0] got_scale,
   output logic [7:0] got_cnt
);
   logic [3:0] wait_cnt;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         msg_ready <= 1'b0;
         wait_cnt <= 4'h0;
         got_cnt <= 8'h0;
         got_value <= 8'h0;
         got_scale <= 2'h0;
      end else if (msg_valid && msg_ready) begin
         msg_ready <= 1'b0;
         wait_cnt <= 4'h0;
         got_cnt <= got_cnt + 8'h1;
         got_value <= msg_value;
         got_scale <= msg_scale;
      end else if (msg_valid) begin
         msg_ready <= (wait_cnt >= stall);
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         msg_ready <= 1'b0;
         wait_cnt <= 4'h0;
      end
   end
endmodule // spl_sink_model
`default_nettype wire

// File: dv/slot_cap_regs_test.sv
// Purpose: self-checking bench for the slot capability register bank
// Assumes: 200 MHz clock, synchronous active-low reset
// Notes: one task per scenario
`timescale 1ns/100ps
`default_nettype none
module slot_cap_regs_test;
   logic sys_clk, nrst, cyc, we, phy, ptn, dl_up, ready, irq, ack, vld;
   logic [7:0] adr, mval, gval, gcnt;
   logic [1:0] mscl, gscl;
   logic [31:0] wdat, rdat, rd;
   logic [3:0] stall, sel;
   int error_cnt = 0;
   int checks = 0;
   int msgs = 0;
   slot_cap_regs u_slot_cap_regs (.sys_clk, .nrst, .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .phy_auto_bw_chg(phy), .partner_auto_bw_chg(ptn), .dl_up,
      .spl_msg_valid(vld), .spl_msg_ready(ready), .spl_msg_value(mval),
      .spl_msg_scale(mscl), .irq);
   spl_sink_model u_spl_sink_model (.sys_clk, .nrst, .msg_valid(vld),
      .msg_ready(ready), .msg_value(mval), .msg_scale(mscl), .stall,
      .got_value(gval), .got_scale(gscl), .got_cnt(gcnt));
   task automatic summarize;
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge sys_clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      rd = rdat;
      cyc <= 1'b0;
      if (n >= 20) error_cnt++;
   endtask
   task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   task automatic exp_msg(input logic [7:0] v, input logic [1:0] s);
      int n;
      n = 0;
      msgs++;
      while (gcnt !== msgs[7:0] && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      chk("msg count", msgs, {24'h0, gcnt});
      chk("msg value", {24'h0, v}, {24'h0, gval});
      chk("msg scale", {30'h0, s}, {30'h0, gscl});
   endtask
   task automatic pulse(input logic p);
      @(posedge sys_clk);
      phy <= p;
      ptn <= !p;
      @(posedge sys_clk);
      phy <= 1'b0;
      ptn <= 1'b0;
   endtask
   task automatic t_reset;
      rchk("slot cap", slot_cap_pkg::ADDR_SLOT_CAP, 32'h0);
      rchk("link word", slot_cap_pkg::ADDR_LINK, 32'h0);
      rchk("unmapped", 8'h7C, 32'h0);
   endtask
   task automatic t_fields;
      bus(1'b1, slot_cap_pkg::ADDR_SLOT_CAP, 32'hFFFFFFFF);
      exp_msg(8'h00, 2'h0);
      rchk("slot cap", slot_cap_pkg::ADDR_SLOT_CAP, 32'h0);
      bus(1'b1, slot_cap_pkg::ADDR_PORT_CFG, 32'h1);
      stall <= 4'h5;
      bus(1'b1, slot_cap_pkg::ADDR_SLOT_CAP, 32'hFFFFFFFF);
      exp_msg(8'hFF, 2'h3);
      rchk("slot cap", slot_cap_pkg::ADDR_SLOT_CAP,
         32'hFFFBFFFF);
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, slot_cap_pkg::ADDR_SLOT_CAP,
            (32'hA5 << 7) | (s << 15));
         exp_msg(8'hA5, s[1:0]);
         rchk("value scale", slot_cap_pkg::ADDR_SLOT_CAP,
            (32'hA5 << 7) | (s << 15));
      end
      dl_up <= 1'b1;
      exp_msg(8'hA5, 2'h3);
      repeat (12) @(posedge sys_clk);
      chk("msg count", msgs, {24'h0, gcnt});
      bus(1'b1, slot_cap_pkg::ADDR_SLOT_CAP, 32'hFFFFFFFF);
      exp_msg(8'hFF, 2'h3);
      bus(1'b1, slot_cap_pkg::ADDR_PORT_CFG, 32'h9);
      bus(1'b1, slot_cap_pkg::ADDR_SLOT_CAP, 32'h0);
      exp_msg(8'h00, 2'h0);
      rchk("locked", slot_cap_pkg::ADDR_SLOT_CAP, 32'hFFFA007F);
   endtask
   task automatic t_bw;
      bus(1'b1, slot_cap_pkg::ADDR_PORT_CFG, 32'h1);
      pulse(1'b1);
      rchk("bw off", slot_cap_pkg::ADDR_LINK, 32'h0);
      bus(1'b1, slot_cap_pkg::ADDR_PORT_CFG, 32'h7);
      pulse(1'b1);
      rchk("bw upstream", slot_cap_pkg::ADDR_LINK, 32'h0);
      bus(1'b1, slot_cap_pkg::ADDR_PORT_CFG, 32'h3);
      pulse(1'b1);
      rchk("bw phy", slot_cap_pkg::ADDR_LINK, 32'h80000000);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, slot_cap_pkg::ADDR_LINK, 32'h0);
      rchk("bw keep", slot_cap_pkg::ADDR_LINK, 32'h80000000);
      sel <= 4'h7;
      bus(1'b1, slot_cap_pkg::ADDR_LINK, 32'h80000000);
      sel <= 4'hF;
      rchk("bw lane", slot_cap_pkg::ADDR_LINK, 32'h80000000);
      bus(1'b1, slot_cap_pkg::ADDR_LINK, 32'h80000000);
      rchk("bw clear", slot_cap_pkg::ADDR_LINK, 32'h0);
      pulse(1'b0);
      rchk("bw partner", slot_cap_pkg::ADDR_LINK, 32'h80000000);
      bus(1'b1, slot_cap_pkg::ADDR_IRQ_MASK, 32'h1);
      chk("irq on", 32'h1, {31'h0, irq});
      bus(1'b1, slot_cap_pkg::ADDR_IRQ_STAT, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rchk("irq status", slot_cap_pkg::ADDR_IRQ_STAT, 32'h2);
      rchk("irq mask", slot_cap_pkg::ADDR_IRQ_MASK, 32'h1);
      rchk("port cfg", slot_cap_pkg::ADDR_PORT_CFG, 32'h3);
      bus(1'b1, slot_cap_pkg::ADDR_IRQ_MASK, 32'h2);
      chk("irq msg", 32'h1, {31'h0, irq});
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      {nrst, cyc, we, phy, ptn, dl_up} = 6'h0;
      adr = 8'h0;
      wdat = 32'h0;
      stall = 4'h0;
      sel = 4'hF;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_fields();
      t_bw();
      summarize();
   end
endmodule // slot_cap_regs_test
`default_nettype wire
